// [common/fplsr_pkg.sv]
// Constants and types shared by the lazy-stacking ready-flag block.
package fplsr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] FPCC_OFFSET   = 12'h000;
  localparam logic [31:0] FPCC_RESET    = 32'h0000_0000;

  // ****************************************************************
  // Field positions inside fp_context_control
  // ****************************************************************
  localparam int BIT_TS     = 26;
  localparam int BIT_VIOL   = 9;
  localparam int BIT_MON    = 8;
  localparam int BIT_SF     = 7;
  localparam int BIT_BF     = 6;
  localparam int BIT_MM     = 5;
  localparam int BIT_HF     = 4;
  localparam int BIT_LAZY_PRESERVATION_ACTIVE = 0;

  // ****************************************************************
  // Bank indices and reset values
  // ****************************************************************
  localparam int   BANK_NS   = 0;
  localparam int   BANK_S    = 1;
  localparam logic TS_RESET  = 1'b0;
  localparam logic FLAG_RESET = 1'b0;

  // ****************************************************************
  // Preservation engine word counts
  // ****************************************************************
  localparam logic [5:0] CALLER_WORDS = 6'h11;
  localparam logic [5:0] TOTAL_WORDS  = 6'h21;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_FINISH
  } fplsr_state_e;

endpackage

// [verilog/fplsr_preserve.sv]
// Deferred floating-point state preservation engine.
`timescale 1ns/1ps

module fplsr_preserve (
  input  wire logic       mclk,          // Core clock.
  input  wire logic       rst_n,         // Asynchronous reset, active low.
  input  wire logic       clkEn,         // Clock enable, freezes state.
  input  wire logic       start,         // Begin one preservation pass.
  input  wire logic       ctxSecure,     // Context belongs to secure state.
  input  wire logic       stackViol,     // Stack limit violation of bank.
  input  wire logic       treatAsSecure, // Registers treated as secure.
  input  wire logic       memWrReady,    // Memory accepts a write.
  output logic            memWrValid,    // Write request to memory.
  output logic [5:0]      memWrIndex,    // Word index of the write.
  output logic            fpZero,        // Pulse: clear the FP registers.
  output logic            busy,          // Engine not idle.
  output logic            done           // Pulse: pass complete.
);

  fplsr_pkg::fplsr_state_e state;
  fplsr_pkg::fplsr_state_e next_state;
  logic [5:0]              limit;
  logic [5:0]              next_limit;
  logic [5:0]              next_memWrIndex;
  logic                    next_memWrValid;
  logic                    next_fpZero;
  logic                    next_done;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    next_state      = state;
    next_limit      = limit;
    next_memWrIndex = memWrIndex;
    next_memWrValid = memWrValid;
    next_fpZero     = 1'b0;
    next_done       = 1'b0;
    case (state)
      fplsr_pkg::ST_IDLE: begin
        if (start) begin
          next_memWrIndex = 6'h00;
          if (stackViol) begin
            // No memory traffic; secure registers still scrubbed.
            next_fpZero = ctxSecure && treatAsSecure;
            next_state  = fplsr_pkg::ST_FINISH;
          end else begin
            // Callee-saved words only when registers count as secure.
            next_limit = (ctxSecure && treatAsSecure) ?
                         fplsr_pkg::TOTAL_WORDS :
                         fplsr_pkg::CALLER_WORDS;
            next_memWrValid = 1'b1;
            next_state      = fplsr_pkg::ST_WRITE;
          end
        end
      end
      fplsr_pkg::ST_WRITE: begin
        if (memWrReady) begin
          if (memWrIndex == limit - 6'h01) begin
            next_memWrValid = 1'b0;
            next_state      = fplsr_pkg::ST_FINISH;
          end else begin
            next_memWrIndex = memWrIndex + 6'h01;
          end
        end
      end
      fplsr_pkg::ST_FINISH: begin
        next_done  = 1'b1;
        next_state = fplsr_pkg::ST_IDLE;
      end
      default: begin
        next_state      = fplsr_pkg::ST_IDLE;
        next_memWrValid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= fplsr_pkg::ST_IDLE;
      limit      <= fplsr_pkg::CALLER_WORDS;
      memWrIndex <= 6'h00;
      memWrValid <= 1'b0;
      fpZero     <= 1'b0;
      done       <= 1'b0;
    end else if (clkEn) begin
      state      <= next_state;
      limit      <= next_limit;
      memWrIndex <= next_memWrIndex;
      memWrValid <= next_memWrValid;
      fpZero     <= next_fpZero;
      done       <= next_done;
    end
  end

  assign busy = (state != fplsr_pkg::ST_IDLE);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cbEngine @(posedge mclk); endclocking
  default disable iff (!rst_n);

  skip_on_viol_a: assert property (
    start && stackViol && clkEn && !busy |=> !memWrValid [*2])
    else $error("Memory write issued despite stack limit violation.");

  zero_secure_a: assert property (
    start && stackViol && ctxSecure && treatAsSecure && clkEn && !busy
    |=> fpZero)
    else $error("Secure registers not zeroed on suppressed preservation.");

  caller_only_a: assert property (
    memWrValid && limit == fplsr_pkg::CALLER_WORDS
    |-> memWrIndex < fplsr_pkg::CALLER_WORDS)
    else $error("Callee-saved word written while not treated as secure.");

endmodule

// [verilog/fplsr_flags.sv]
// Ready and stack-limit flags of the FP context control register, APB slave.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

// What this block does
// - Banked stack-limit violation flag at bit 9.
// - Violation set skips all preservation memory writes.
// - Suppressed pass still zeroes secure registers when TS.
// - Shared debug-monitor-ready flag at bit 8.
// - Monitor flag RAZ/WI non-secure when enable set.
// - Secure-fault-ready at bit 7, non-secure RAZ/WI.
// - Bus-fault-ready bit 6, RAZ/WI non-secure gated.
// - Banked memory-management-ready flag at bit 5.
// - Hard-fault-ready bit 4, RAZ/WI non-secure gated.
// - Banked lazy-preservation-active flag at bit 0.
// - TS clear means no callee-saved register push.
module fplsr_flags (
  input  wire logic        mclk,                // Core clock, 25 MHz.
  input  wire logic        rst_n,               // Async reset, active low.
  input  wire logic        clkEn,               // Clock enable.
  input  wire logic        psel,                // APB select.
  input  wire logic        penable,             // APB enable.
  input  wire logic        pwrite,              // APB direction.
  input  wire logic [11:0] paddr,               // APB byte address.
  input  wire logic [31:0] pwdata,              // APB write data.
  input  wire logic [2:0]  pprot,               // APB protection.
  output logic             pready,              // APB ready.
  output logic [31:0]      prdata,              // APB read data.
  output logic             pslverr,             // APB error.
  input  wire logic        secureDebugMonitorEnable, // Monitor secured.
  input  wire logic        faultsToNonSecure,   // Faults routed NS.
  input  wire logic        frameAlloc,          // Pulse: FP frame made.
  input  wire logic        allocSecure,         // Frame of secure state.
  input  wire logic        allocStackLimitViol, // Frame breaks limit.
  input  wire logic        allocMonRdy,         // Monitor pendable.
  input  wire logic        allocSfRdy,          // Secure fault pendable.
  input  wire logic        allocBfRdy,          // Bus fault pendable.
  input  wire logic        allocMmRdy,          // Mem manage pendable.
  input  wire logic        allocHfRdy,          // Hard fault pendable.
  input  wire logic        preserveReq,         // Pulse: FP op, lazy due.
  input  wire logic        preserveSecure,      // Bank of that context.
  input  wire logic        memWrReady,          // Memory accepts write.
  output logic             memWrValid,          // Preservation write.
  output logic [5:0]       memWrIndex,          // Word index of write.
  output logic             fpZero,              // Pulse: zero FP regs.
  output logic             preserveDone,        // Pulse: pass finished.
  output logic             treatAsSecure        // Current TS control.
);

  logic [1:0]  stackLimitViolation;
  logic [1:0]  memManageReady;
  logic [1:0]  lazyPreservationActive;
  logic        debugMonitorReady;
  logic        secureFaultReady;
  logic        busFaultReady;
  logic        hardFaultReady;
  logic        next_treatAsSecure;
  logic        next_debugMonitorReady;
  logic        next_secureFaultReady;
  logic        next_busFaultReady;
  logic        next_hardFaultReady;
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [31:0] readView;
  logic        accSecure;
  logic        mapped;
  logic        wrEn;
  logic        monVisible;
  logic        faultVisible;
  logic        engStart;
  logic        engBusy;
  logic        engBank;

  // ****************************************************************
  // Access decode
  // ****************************************************************
  // A clear pprot[1] marks a secure access.
  assign accSecure    = !pprot[1];
  assign mapped       = (paddr[11:2] == fplsr_pkg::FPCC_OFFSET[11:2]);
  assign wrEn         = psel && penable && pready && pwrite && mapped;
  assign monVisible   = accSecure || !secureDebugMonitorEnable;
  assign faultVisible = accSecure || faultsToNonSecure;

  always_comb begin
    readView = fplsr_pkg::FPCC_RESET;
    readView[fplsr_pkg::BIT_TS] = treatAsSecure;
    // Banked fields: the accessor's own copy.
    readView[fplsr_pkg::BIT_VIOL] =
      stackLimitViolation[accSecure];
    readView[fplsr_pkg::BIT_MM] = memManageReady[accSecure];
    readView[fplsr_pkg::BIT_LAZY_PRESERVATION_ACTIVE] =
      lazyPreservationActive[accSecure];
    readView[fplsr_pkg::BIT_MON] = monVisible && debugMonitorReady;
    readView[fplsr_pkg::BIT_SF]  = accSecure && secureFaultReady;
    readView[fplsr_pkg::BIT_BF]  = faultVisible && busFaultReady;
    readView[fplsr_pkg::BIT_HF]  = faultVisible && hardFaultReady;
  end

  // ****************************************************************
  // APB answer: one wait state, read data sampled with it
  // ****************************************************************
  always_comb begin
    next_pready  = 1'b0;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_pready  = 1'b1;
      next_pslverr = !mapped;
      next_prdata  = (mapped && !pwrite) ? readView : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************************************
  // Banked flags, one copy per security state
  // ****************************************************************
  // Capture beats a software write and the engine's clear in the
  // same cycle, so a frame allocation is never lost.
  for (genvar b = 0; b < 2; b++) begin : gBank
    logic viol;
    logic mm;
    logic lsp;
    logic next_viol;
    logic next_mm;
    logic next_lsp;

    always_comb begin
      next_viol = viol;
      next_mm   = mm;
      next_lsp  = lsp;
      if (wrEn && (accSecure == b[0])) begin
        next_viol = pwdata[fplsr_pkg::BIT_VIOL];
        next_mm   = pwdata[fplsr_pkg::BIT_MM];
        next_lsp  = pwdata[fplsr_pkg::BIT_LAZY_PRESERVATION_ACTIVE];
      end
      if (preserveDone && (engBank == b[0])) begin
        next_lsp = 1'b0;
      end
      if (frameAlloc && (allocSecure == b[0])) begin
        next_viol = allocStackLimitViol;
        next_mm   = allocMmRdy;
        next_lsp  = 1'b1;
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        viol <= fplsr_pkg::FLAG_RESET;
        mm   <= fplsr_pkg::FLAG_RESET;
        lsp  <= fplsr_pkg::FLAG_RESET;
      end else if (clkEn) begin
        viol <= next_viol;
        mm   <= next_mm;
        lsp  <= next_lsp;
      end
    end

    assign stackLimitViolation[b]    = viol;
    assign memManageReady[b]         = mm;
    assign lazyPreservationActive[b] = lsp;
  end

  // ****************************************************************
  // Shared flags and the treat-as-secure control
  // ****************************************************************
  always_comb begin
    next_treatAsSecure     = treatAsSecure;
    next_debugMonitorReady = debugMonitorReady;
    next_secureFaultReady  = secureFaultReady;
    next_busFaultReady     = busFaultReady;
    next_hardFaultReady    = hardFaultReady;
    if (wrEn) begin
      if (accSecure) begin
        next_treatAsSecure    = pwdata[fplsr_pkg::BIT_TS];
        next_secureFaultReady = pwdata[fplsr_pkg::BIT_SF];
      end
      if (monVisible) begin
        next_debugMonitorReady = pwdata[fplsr_pkg::BIT_MON];
      end
      if (faultVisible) begin
        next_busFaultReady  = pwdata[fplsr_pkg::BIT_BF];
        next_hardFaultReady = pwdata[fplsr_pkg::BIT_HF];
      end
    end
    if (frameAlloc) begin
      next_debugMonitorReady = allocMonRdy;
      next_secureFaultReady  = allocSfRdy;
      next_busFaultReady     = allocBfRdy;
      next_hardFaultReady    = allocHfRdy;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      treatAsSecure     <= fplsr_pkg::TS_RESET;
      debugMonitorReady <= fplsr_pkg::FLAG_RESET;
      secureFaultReady  <= fplsr_pkg::FLAG_RESET;
      busFaultReady     <= fplsr_pkg::FLAG_RESET;
      hardFaultReady    <= fplsr_pkg::FLAG_RESET;
    end else if (clkEn) begin
      treatAsSecure     <= next_treatAsSecure;
      debugMonitorReady <= next_debugMonitorReady;
      secureFaultReady  <= next_secureFaultReady;
      busFaultReady     <= next_busFaultReady;
      hardFaultReady    <= next_hardFaultReady;
    end
  end

  // ****************************************************************
  // Preservation engine
  // ****************************************************************
  // A request is dropped if its bank has no pending lazy state or the
  // engine is still busy; the core repeats it on the next FP op.
  assign engStart = preserveReq && !engBusy &&
                    lazyPreservationActive[preserveSecure];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      engBank <= 1'b0;
    end else if (clkEn && engStart) begin
      engBank <= preserveSecure;
    end
  end

  fplsr_preserve uPreserve (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .clkEn         (clkEn),
    .start         (engStart),
    .ctxSecure     (preserveSecure),
    .stackViol     (stackLimitViolation[preserveSecure]),
    .treatAsSecure (treatAsSecure),
    .memWrReady    (memWrReady),
    .memWrValid    (memWrValid),
    .memWrIndex    (memWrIndex),
    .fpZero        (fpZero),
    .busy          (engBusy),
    .done          (preserveDone)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  // All checks here live in the core clock domain.
  default clocking cbFlags @(posedge mclk); endclocking
  default disable iff (!rst_n);

  viol_capture_a: assert property (
    clkEn && frameAlloc && allocSecure
    |=> stackLimitViolation[1] == $past(allocStackLimitViol))
    else $error("Secure violation flag not captured at allocation.");

  mon_capture_a: assert property (
    clkEn && frameAlloc |=> debugMonitorReady == $past(allocMonRdy))
    else $error("Monitor ready flag not captured at allocation.");

  mon_raz_a: assert property (
    clkEn && psel && penable && !pready && pprot[1] &&
    secureDebugMonitorEnable |=> !prdata[fplsr_pkg::BIT_MON])
    else $error("Monitor ready visible to non-secure with monitor secured.");

  sf_raz_a: assert property (
    clkEn && psel && penable && !pready && pprot[1]
    |=> pready && !prdata[fplsr_pkg::BIT_SF])
    else $error("Secure fault ready visible to non-secure access.");

  fault_raz_a: assert property (
    clkEn && psel && penable && !pready && pprot[1] && !faultsToNonSecure
    |=> prdata[fplsr_pkg::BIT_BF] == 1'b0 &&
        prdata[fplsr_pkg::BIT_HF] == 1'b0)
    else $error("Bus or hard fault ready visible to non-secure.");

  // Only a mapped read returns the field; writes and errors answer zero.
  mm_bank_a: assert property (
    clkEn && psel && penable && !pready && !pprot[1] && mapped && !pwrite
    |=> prdata[fplsr_pkg::BIT_MM] == $past(memManageReady[1]))
    else $error("Secure read did not return the secure mem manage copy.");

  lsp_set_a: assert property (
    clkEn && frameAlloc && !allocSecure |=> lazyPreservationActive[0])
    else $error("Lazy active not set on non-secure allocation.");

  hold_flags_a: assert property (
    !frameAlloc && !wrEn
    |=> $stable(busFaultReady) && $stable(hardFaultReady))
    else $error("Ready flag changed without allocation or write.");

  answer_a: assert property (
    clkEn && psel && penable && !pready |=> pready)
    else $error("APB access not answered after one wait state.");

  cov_alloc_c: cover property (
    clkEn && frameAlloc && allocStackLimitViol);
  cov_write_c: cover property (
    clkEn && memWrValid && memWrReady);
  cov_zero_c: cover property (
    fpZero);
  cov_nsread_c: cover property (
    psel && penable && pready && pprot[1] && !pwrite);

endmodule

// [verif/fplsr_tb.sv]
// Self-checking testbench of the lazy-stacking ready-flag block.
`timescale 1ns/1ps

module testbench;
  // ****************************************************************
  // Stimulus signals and reference model state
  // ****************************************************************
  logic        mclk = 1'b0, rst_n = 1'b0, clkEn = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  pprot = 3'h0;
  logic        secureDebugMonitorEnable = 1'b0, faultsToNonSecure = 1'b0;
  logic        frameAlloc = 1'b0, allocSecure = 1'b0;
  logic        allocStackLimitViol = 1'b0, allocMonRdy = 1'b0;
  logic        allocSfRdy = 1'b0, allocBfRdy = 1'b0;
  logic        allocMmRdy = 1'b0, allocHfRdy = 1'b0;
  logic        preserveReq = 1'b0, preserveSecure = 1'b0, memWrReady = 1'b0;
  logic        pready, pslverr, memWrValid, fpZero, preserveDone;
  logic        treatAsSecure;
  logic [31:0] prdata;
  logic [5:0]  memWrIndex;
  logic        ts = 1'b0, mon = 1'b0, sf = 1'b0, bf = 1'b0, hf = 1'b0;
  logic [1:0]  viol = 2'h0, mm = 2'h0, lz = 2'h0;
  logic [33:0] expQ[$];
  logic [33:0] note;
  integer      seed = 32'h116d;
  int          n_fail = 0, num_checks = 0, i;

  fplsr_flags dut (.mclk, .rst_n, .clkEn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pprot, .pready, .prdata, .pslverr, .secureDebugMonitorEnable,
    .faultsToNonSecure, .frameAlloc, .allocSecure, .allocStackLimitViol,
    .allocMonRdy, .allocSfRdy, .allocBfRdy, .allocMmRdy, .allocHfRdy,
    .preserveReq, .preserveSecure, .memWrReady, .memWrValid, .memWrIndex,
    .fpZero, .preserveDone, .treatAsSecure);

  always #20 mclk = ~mclk;

  // Memory stalls at random so the engine must hold each write request.
  always @(posedge mclk) memWrReady <= 1'($random(seed) & 1);

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] expv(input logic ns);
    logic [31:0] v;
    v = 32'h0;
    v[26] = ts;
    v[9] = viol[!ns];
    v[8] = mon & !(ns & secureDebugMonitorEnable);
    v[7] = sf & !ns;
    v[6] = bf & !(ns & !faultsToNonSecure);
    v[5] = mm[!ns];
    v[4] = hf & !(ns & !faultsToNonSecure);
    v[0] = lz[!ns];
    return v;
  endfunction

  task automatic apb(input logic wr, input logic ns, input logic [11:0] a,
                     input logic [31:0] dIn);
    logic [31:0] d;
    logic        b;
    int          n;
    d = dIn;
    b = !ns;
    // Lazy-active is kept as is, since its software write path is open.
    if (wr) d[0] = lz[b];
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pprot <= {1'b0, ns, 1'b0};
    if (a != 12'h000) expQ.push_back({!wr, 1'b1, 32'h0});
    else expQ.push_back({!wr, 1'b0, wr ? 32'h0 : expv(ns)});
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr && a == 12'h000) begin
      viol[b] = d[9];
      mm[b] = d[5];
      if (!ns) ts = d[26];
      if (!ns) sf = d[7];
      if (!ns || !secureDebugMonitorEnable) mon = d[8];
      if (!ns || faultsToNonSecure) bf = d[6];
      if (!ns || faultsToNonSecure) hf = d[4];
    end
  endtask

  task automatic alloc(input logic b, input logic v);
    logic [31:0] r;
    r = $random(seed);
    @(posedge mclk);
    frameAlloc <= 1'b1;
    allocSecure <= b;
    allocStackLimitViol <= v;
    {allocMonRdy, allocSfRdy, allocBfRdy, allocMmRdy, allocHfRdy} <= r[4:0];
    @(posedge mclk);
    frameAlloc <= 1'b0;
    {mon, sf, bf, hf} = {r[4:2], r[0]};
    {viol[b], mm[b], lz[b]} = {v, r[1], 1'b1};
  endtask

  task automatic preserve(input logic b, input int words, input logic z);
    int   cnt, n;
    logic sawV, sawZ;
    @(posedge mclk);
    preserveReq <= 1'b1;
    preserveSecure <= b;
    @(posedge mclk);
    preserveReq <= 1'b0;
    {cnt, n, sawV, sawZ} = '0;
    do begin
      @(posedge mclk);
      n++;
      if (memWrValid === 1'b1) sawV = 1'b1;
      if (fpZero === 1'b1) sawZ = 1'b1;
      if (memWrValid === 1'b1 && memWrReady === 1'b1) begin
        check({26'h0, memWrIndex}, 32'(cnt));
        cnt++;
      end
    end while (preserveDone !== 1'b1 && n < 300);
    check({31'h0, preserveDone}, 32'h1);
    check(32'(cnt), 32'(words));
    check({31'h0, sawV}, {31'h0, words != 0});
    check({31'h0, sawZ}, {31'h0, z});
    lz[b] = 1'b0;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // Result watcher and watchdog
  // ****************************************************************
  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      if (expQ.size() == 0) n_fail++;
      else begin
        note = expQ.pop_front();
        check({31'h0, pslverr}, {31'h0, note[32]});
        if (note[33]) check(prdata, note[31:0]);
      end
    end
  end

  initial begin
    #800000;
    n_fail++;
    summarize();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, 1'b0, 12'h000, 32'h0);
    apb(1'b0, 1'b1, 12'h000, 32'h0);
    $display("reset values done");
    for (i = 0; i < 4; i++) begin
      secureDebugMonitorEnable <= i[0];
      faultsToNonSecure <= i[1];
      alloc(i[0], 1'($random(seed)));
      apb(1'b0, 1'b0, 12'h000, 32'h0);
      apb(1'b0, 1'b1, 12'h000, 32'h0);
      apb(1'b1, 1'b0, 12'h000, $random(seed));
      apb(1'b1, 1'b1, 12'h000, $random(seed));
      apb(1'b0, 1'b0, 12'h000, 32'h0);
      apb(1'b0, 1'b1, 12'h000, 32'h0);
      check({31'h0, treatAsSecure}, {31'h0, ts});
    end
    $display("views and banking done");
    apb(1'b0, 1'b0, 12'h004, 32'h0);
    apb(1'b1, 1'b0, 12'hFFC, 32'hFFFF_FFFF);
    apb(1'b0, 1'b0, 12'h000, 32'h0);
    $display("unmapped access done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 1'b0, 12'h000, {5'h0, i[0], 26'h0});
      alloc(1'b1, i[1]);
      preserve(1'b1, i[1] ? 0 : (i[0] ? 33 : 17), i[1] & i[0]);
      apb(1'b0, 1'b0, 12'h000, 32'h0);
    end
    $display("preservation done");
    // An allocation while the clock enable is low must leave all as it was.
    @(posedge mclk);
    clkEn <= 1'b0;
    frameAlloc <= 1'b1;
    allocSecure <= 1'b1;
    allocStackLimitViol <= !viol[1];
    @(posedge mclk);
    clkEn <= 1'b1;
    frameAlloc <= 1'b0;
    apb(1'b0, 1'b0, 12'h000, 32'h0);
    $display("clock enable done");
    summarize();
  end
endmodule
